/* common/cce_pkg.sv */
package cce_pkg;

  // Register offsets on the 4-bit register port.
  localparam logic [3:0] OFS_CTRL_ZERO = 4'h0;
  localparam logic [3:0] OFS_CTRL_ONE = 4'h1;
  localparam logic [3:0] OFS_DATA_LO = 4'h2;
  localparam logic [3:0] OFS_DATA_HI = 4'h3;
  localparam logic [3:0] OFS_ACC_LO = 4'h4;
  localparam logic [3:0] OFS_ACC_HI = 4'h5;
  localparam logic [3:0] OFS_SHIFT_LO = 4'h6;
  localparam logic [3:0] OFS_SHIFT_HI = 4'h7;
  localparam logic [3:0] OFS_POLY_LO = 4'h8;
  localparam logic [3:0] OFS_POLY_HI = 4'h9;
  localparam logic [3:0] OFS_FLAG = 4'ha;
  localparam logic [3:0] OFS_IRQ_EN = 4'hb;

  // Field positions in engine_control_zero.
  localparam int BIT_SHIFT_ORDER = 0;
  localparam int BIT_AUGMENT = 1;
  localparam int BIT_START = 4;
  localparam int BIT_BUSY = 5;
  localparam int BIT_FULL = 6;

  // Field positions in engine_control_one.
  localparam int POS_DATA_LENGTH_FIELD = 0;
  localparam int POS_POLY_LENGTH_FIELD = 4;
  localparam int LEN_W = 4;

  // Bit positions in the flag and enable registers.
  localparam int BIT_COMPLETION = 0;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_LEN = 4'h0;

endpackage

/* src/cce_crc_step.sv */
`timescale 1ns/1ps
// One shift of the XOR feedback register for an accumulator of poly_length_field+1 bits.
module cce_crc_step (
  // Accumulator and polynomial
  input wire logic [15:0] acc_i,
  input wire logic [15:0] poly_i,
  input wire logic [3:0] poly_length_field_i,
  // Bit and mode
  input wire logic bit_i,
  input wire logic augment_i,
  // Result
  output logic [15:0] acc_o
);

  logic [15:0] mask;
  logic msb;
  logic fb;
  logic [15:0] shifted;

  always_comb begin
    mask = 16'hffff >> (4'hf - poly_length_field_i);
    msb = acc_i[poly_length_field_i];
    if (augment_i) begin
      // The direct form gives the result of appending poly_length_field+1 zeros.
      fb = msb ^ bit_i;
      shifted = {acc_i[14:0], 1'b0};
    end else begin
      fb = msb;
      shifted = {acc_i[14:0], bit_i};
    end
    acc_o = (shifted ^ (fb ? poly_i : 16'h0000)) & mask;
  end

endmodule

/* src/cce_crc_engine.sv */
`timescale 1ns/1ps
// Function
// - Accumulator up to 16, polynomial up to 17.
// - Width follows poly length field plus one.
// - Polynomial end terms forced to one.
// - Polynomial bit zero reads zero, computes one.
// - Only data bits within data length used.
// - Shift order clear: top bit first.
// - Shift order set: lowest bit first.
// - Accumulator writable as seed, computation continues.
// - Low data write latches both data bytes.
// - Augment set: zeros appended to the data.
// - Augment clear: stop after last data bit.
// - Shift order and augment give reversed result.
// - XOR feedback shift register does division.
// - Check value readable in accumulator registers.
// - Completion event on busy falling edge.
// - Flag always set; request needs enable.
// - Only software clears completion flag.
// - Data from software or memory scanner.
// - Data length field holds word length minus one.
// - Shifting begins only after start bit set.
// - Full shows occupied input; high byte first.
// - Busy holds until final value present.
module cce_crc_engine #(
  parameter int ACC_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // Memory scanner word input
  input wire logic scan_valid_i,
  input wire logic [15:0] scan_data_i,
  output logic scan_ready_o,
  // Interrupt request
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////

  generate
    if (ACC_W != 16) begin : g_bad_width
      $error("ACC_W must be 16 to match the 4-bit length fields.");
    end
  endgenerate

  typedef struct packed {
    logic shift_order;
    logic augment;
    logic start;
    logic [3:0] data_length_field;
    logic [3:0] poly_length_field;
    logic [7:0] data_hi;
    logic [7:0] data_lo;
    logic [15:0] acc;
    logic [15:0] poly;
    logic [15:0] stage;
    logic full;
    logic [15:0] shifter;
    logic [3:0] count;
    logic shifting;
    logic busy;
    logic flag;
    logic irq_en;
    logic [7:0] rd_data;
    logic scan_ready;
    logic irq;
  } cce_state_t;

  cce_state_t st_r;
  cce_state_t st_nxt;

  logic [15:0] poly_eff;
  logic [15:0] acc_step;
  logic next_bit;
  logic sw_latch;
  logic scan_take;
  logic load;
  logic last_bit;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] ctrl_zero(input cce_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[cce_pkg::BIT_SHIFT_ORDER] = s.shift_order;
    v[cce_pkg::BIT_AUGMENT] = s.augment;
    v[cce_pkg::BIT_START] = s.start;
    v[cce_pkg::BIT_BUSY] = s.busy;
    v[cce_pkg::BIT_FULL] = s.full;
    ctrl_zero = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Hardware supplies bit zero of the polynomial; the top term is implicit.
  assign poly_eff = {st_r.poly[15:1], 1'b1};

  // Next bit comes from the data length position or from bit zero.
  assign next_bit = st_r.shift_order ? st_r.shifter[0]
                                     : st_r.shifter[st_r.data_length_field];

  cce_crc_step u_step (
    .acc_i(st_r.acc),
    .poly_i(poly_eff),
    .poly_length_field_i(st_r.poly_length_field),
    .bit_i(next_bit),
    .augment_i(st_r.augment),
    .acc_o(acc_step)
  );

  assign sw_latch = wr_i && hit(addr_i, cce_pkg::OFS_DATA_LO);
  assign scan_take = scan_valid_i && st_r.scan_ready;
  assign last_bit = st_r.shifting && (st_r.count == 4'h0);
  // A word moves from the stage only when the shifter is free or finishing.
  assign load = st_r.start && st_r.full &&
                (!st_r.shifting || last_bit);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt = st_r;

    // Software register writes.
    if (wr_i) begin
      unique case (1'b1)
        hit(addr_i, cce_pkg::OFS_CTRL_ZERO): begin
          st_nxt.shift_order = wr_data_i[cce_pkg::BIT_SHIFT_ORDER];
          st_nxt.augment = wr_data_i[cce_pkg::BIT_AUGMENT];
          st_nxt.start = wr_data_i[cce_pkg::BIT_START];
        end
        hit(addr_i, cce_pkg::OFS_CTRL_ONE): begin
          st_nxt.data_length_field = wr_data_i[cce_pkg::POS_DATA_LENGTH_FIELD +: cce_pkg::LEN_W];
          st_nxt.poly_length_field = wr_data_i[cce_pkg::POS_POLY_LENGTH_FIELD +: cce_pkg::LEN_W];
        end
        hit(addr_i, cce_pkg::OFS_DATA_LO): begin
          st_nxt.data_lo = wr_data_i;
        end
        hit(addr_i, cce_pkg::OFS_DATA_HI): begin
          st_nxt.data_hi = wr_data_i;
        end
        hit(addr_i, cce_pkg::OFS_ACC_LO): begin
          st_nxt.acc[7:0] = wr_data_i;
        end
        hit(addr_i, cce_pkg::OFS_ACC_HI): begin
          st_nxt.acc[15:8] = wr_data_i;
        end
        hit(addr_i, cce_pkg::OFS_POLY_LO): begin
          st_nxt.poly[7:0] = {wr_data_i[7:1], 1'b0};
        end
        hit(addr_i, cce_pkg::OFS_POLY_HI): begin
          st_nxt.poly[15:8] = wr_data_i;
        end
        hit(addr_i, cce_pkg::OFS_FLAG): begin
          if (!wr_data_i[cce_pkg::BIT_COMPLETION]) begin
            st_nxt.flag = 1'b0;
          end
        end
        hit(addr_i, cce_pkg::OFS_IRQ_EN): begin
          st_nxt.irq_en = wr_data_i[cce_pkg::BIT_COMPLETION];
        end
        default: begin
        end
      endcase
    end

    // Bit shifting, one bit per clock.
    if (st_r.shifting) begin
      st_nxt.acc = acc_step;
      if (st_r.shift_order) begin
        st_nxt.shifter = {1'b0, st_r.shifter[15:1]};
      end else begin
        st_nxt.shifter = {st_r.shifter[14:0], 1'b0};
      end
      st_nxt.count = st_r.count - 4'h1;
      if (last_bit) begin
        st_nxt.shifting = 1'b0;
      end
    end

    // Stage to shifter; the length is taken at load time.
    if (load) begin
      st_nxt.shifter = st_r.stage;
      st_nxt.count = st_r.data_length_field;
      st_nxt.shifting = 1'b1;
      st_nxt.full = 1'b0;
    end

    // New word into the stage; the scanner wins over software.
    if (scan_take) begin
      st_nxt.stage = scan_data_i;
      st_nxt.full = 1'b1;
    end else if (sw_latch) begin
      st_nxt.stage = {st_r.data_hi, wr_data_i};
      st_nxt.full = 1'b1;
    end

    // Busy covers a waiting word and the word being shifted.
    st_nxt.busy = st_nxt.shifting || (st_nxt.full && st_nxt.start);

    // Completion on busy falling; the set wins over a clear.
    if (st_r.busy && !st_nxt.busy) begin
      st_nxt.flag = 1'b1;
    end
    st_nxt.irq = st_nxt.flag && st_nxt.irq_en;

    // Scanner is offered a slot only when the stage is free.
    st_nxt.scan_ready = st_nxt.start && !st_nxt.full && !sw_latch;

    // Read data stands in the cycle after the strobe.
    st_nxt.rd_data = 8'h00;
    if (rd_i) begin
      unique case (1'b1)
        hit(addr_i, cce_pkg::OFS_CTRL_ZERO): begin
          st_nxt.rd_data = ctrl_zero(st_r);
        end
        hit(addr_i, cce_pkg::OFS_CTRL_ONE): begin
          st_nxt.rd_data = {st_r.poly_length_field, st_r.data_length_field};
        end
        hit(addr_i, cce_pkg::OFS_DATA_LO): begin
          st_nxt.rd_data = st_r.data_lo;
        end
        hit(addr_i, cce_pkg::OFS_DATA_HI): begin
          st_nxt.rd_data = st_r.data_hi;
        end
        hit(addr_i, cce_pkg::OFS_ACC_LO): begin
          st_nxt.rd_data = st_r.acc[7:0];
        end
        hit(addr_i, cce_pkg::OFS_ACC_HI): begin
          st_nxt.rd_data = st_r.acc[15:8];
        end
        hit(addr_i, cce_pkg::OFS_SHIFT_LO): begin
          st_nxt.rd_data = st_r.shifter[7:0];
        end
        hit(addr_i, cce_pkg::OFS_SHIFT_HI): begin
          st_nxt.rd_data = st_r.shifter[15:8];
        end
        hit(addr_i, cce_pkg::OFS_POLY_LO): begin
          st_nxt.rd_data = {st_r.poly[7:1], 1'b0};
        end
        hit(addr_i, cce_pkg::OFS_POLY_HI): begin
          st_nxt.rd_data = st_r.poly[15:8];
        end
        hit(addr_i, cce_pkg::OFS_FLAG): begin
          st_nxt.rd_data = {7'h00, st_r.flag};
        end
        hit(addr_i, cce_pkg::OFS_IRQ_EN): begin
          st_nxt.rd_data = {7'h00, st_r.irq_en};
        end
        default: begin
          st_nxt.rd_data = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r.shift_order <= 1'b0;
      st_r.augment <= 1'b0;
      st_r.start <= 1'b0;
      st_r.data_length_field <= cce_pkg::RST_LEN;
      st_r.poly_length_field <= cce_pkg::RST_LEN;
      st_r.data_hi <= cce_pkg::RST_BYTE;
      st_r.data_lo <= cce_pkg::RST_BYTE;
      st_r.acc <= cce_pkg::RST_WORD;
      st_r.poly <= cce_pkg::RST_WORD;
      st_r.stage <= cce_pkg::RST_WORD;
      st_r.full <= 1'b0;
      st_r.shifter <= cce_pkg::RST_WORD;
      st_r.count <= cce_pkg::RST_LEN;
      st_r.shifting <= 1'b0;
      st_r.busy <= 1'b0;
      st_r.flag <= 1'b0;
      st_r.irq_en <= 1'b0;
      st_r.rd_data <= cce_pkg::RST_BYTE;
      st_r.scan_ready <= 1'b0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Outputs come straight from the state register.
  assign rd_data_o = st_r.rd_data;
  assign scan_ready_o = st_r.scan_ready;
  assign irq_o = st_r.irq;

endmodule

/* dv/cce_crc_engine_properties.sv */
`timescale 1ns/1ps
module cce_crc_engine_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  // Scanner and interrupt
  input wire logic scan_valid_i,
  input wire logic [15:0] scan_data_i,
  input wire logic scan_ready_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic en_r;
  logic go_r;
  wire w_fl = wr_i && (addr_i == cce_pkg::OFS_FLAG ||
    addr_i == cce_pkg::OFS_IRQ_EN);
  wire w_c0 = wr_i && addr_i == cce_pkg::OFS_CTRL_ZERO;
  wire w_en = wr_i && addr_i == cce_pkg::OFS_IRQ_EN;
  // Shadow copies of the enable and start bits.
  always_ff @(posedge clk_i) begin
    en_r <= reset_i ? 1'b0 : (w_en ? wr_data_i[0] : en_r);
    go_r <= reset_i ? 1'b0 : (w_c0 ? wr_data_i[4] : go_r);
  end
  a_read_idle_zero: assert property (
    !$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (
    $past(rd_i) && $past(addr_i) >= 4'hc |-> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_poly_lsb_zero: assert property ($past(rd_i) &&
    $past(addr_i) == cce_pkg::OFS_POLY_LO |-> !rd_data_o[0])
    else $error("polynomial bit zero reads one");
  a_ctrl_spare_zero: assert property ($past(rd_i) &&
    $past(addr_i) == cce_pkg::OFS_CTRL_ZERO |-> rd_data_o[7] == 1'b0 &&
    rd_data_o[3:2] == 2'b00) else $error("spare control bits set");
  a_irq_needs_en: assert property (
    !en_r && !$past(en_r) |-> !irq_o)
    else $error("request without enable");
  a_irq_fall_sw: assert property ($fell(irq_o) |-> $past(w_fl) ||
    $past(w_fl, 2)) else $error("request dropped without write");
  a_ready_needs_go: assert property (
    scan_ready_o |-> go_r || $past(go_r))
    else $error("scanner ready without start");
  a_take_drops_ready: assert property (
    scan_valid_i && scan_ready_o |=> !scan_ready_o)
    else $error("ready stays after take");
  c_scan_take: cover property (scan_valid_i && scan_ready_o);
  c_irq_rise: cover property ($rose(irq_o));
  c_acc_read: cover property (rd_i && addr_i == cce_pkg::OFS_ACC_LO);
endmodule
bind cce_crc_engine cce_crc_engine_properties u_props (.clk_i(clk_i),
  .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .scan_valid_i(scan_valid_i),
  .scan_data_i(scan_data_i), .scan_ready_o(scan_ready_o), .irq_o(irq_o));

/* dv/cce_scan_model.sv */
`timescale 1ns/1ps
module cce_scan_model (
  // Clock, reset and control
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [15:0] base_i,
  input wire logic [3:0] cnt_i,
  // Word handshake
  input wire logic ready_i,
  output logic valid_o,
  output logic [15:0] data_o,
  output logic done_o
);
  logic [3:0] n;
  logic [1:0] gap;
  // Words base+n are offered and held until taken; idle data toggles.
  always_ff @(posedge clk_i) begin
    if (reset_i || !go_i) begin
      n <= 4'h0;
      gap <= 2'h0;
      valid_o <= 1'b0;
      data_o <= 16'hffff;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
      n <= n + 4'h1;
      gap <= {slow_i, slow_i};
    end else if (!valid_o && gap == 2'h0 && n < cnt_i) begin
      valid_o <= 1'b1;
      data_o <= base_i + {12'h000, n};
    end else if (!valid_o) begin
      gap <= (gap == 2'h0) ? 2'h0 : gap - 2'h1;
      data_o <= ~data_o;
    end
  end
  assign done_o = go_i && n == cnt_i;
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_top;
  logic clk_i, reset_i, wr, rd, sv, sr, irq, go, slow, done;
  logic [3:0] addr, cnt;
  logic [7:0] wdat, rdat, d;
  logic [15:0] sd, base, v, e;
  int n_fail = 0, check_count = 0, poly_length_field_v, data_length_field_v, sm_v, am_v;
  logic [15:0] poly_v;
  cce_crc_engine #(.ACC_W(16)) DUT (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr), .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
    .scan_valid_i(sv), .scan_data_i(sd), .scan_ready_o(sr), .irq_o(irq));
  cce_scan_model SCN (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
    .slow_i(slow), .base_i(base), .cnt_i(cnt), .ready_i(sr), .valid_o(sv),
    .data_o(sd), .done_o(done));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic wrr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_i);
    addr <= a;
    wdat <= x;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    x = rdat;
  endtask
  task automatic acc(output logic [15:0] x);
    rdr(cce_pkg::OFS_ACC_LO, x[7:0]);
    rdr(cce_pkg::OFS_ACC_HI, x[15:8]);
  endtask
  task automatic wait_bit(input int b, input logic x);
    for (int i = 0; i < 300; i++) begin
      rdr(cce_pkg::OFS_CTRL_ZERO, d);
      if (d[b] === x) break;
    end
    `CHK(d[b], x)
  endtask
  task automatic word(input logic [15:0] w);
    wrr(cce_pkg::OFS_DATA_HI, w[15:8]);
    wrr(cce_pkg::OFS_DATA_LO, w[7:0]);
    wait_bit(cce_pkg::BIT_FULL, 1'b0);
  endtask
  function automatic logic [15:0] crc_f(input logic [15:0] a,
    input logic [15:0] w);
    logic [15:0] p;
    logic [16:0] m;
    logic b, t;
    p = {poly_v[15:1], 1'b1};
    m = (17'h1 << (poly_length_field_v + 1)) - 17'h1;
    for (int i = 0; i <= data_length_field_v; i++) begin
      b = sm_v ? w[i] : w[data_length_field_v - i];
      t = a[poly_length_field_v];
      if (am_v) a = (a << 1) ^ ((t ^ b) ? p : 16'h0);
      else a = ((a << 1) | {15'h0, b}) ^ (t ? p : 16'h0);
      a = a & m[15:0];
    end
    return a;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    end_sim;
  end
  initial begin
    {wr, rd, go, slow, addr, wdat, base, cnt} = '0;
    reset_i = 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rdr(4'(a), d);
      `CHK(d, 8'h00)
    end
    wrr(cce_pkg::OFS_POLY_LO, 8'h05);
    wrr(cce_pkg::OFS_POLY_HI, 8'h80);
    rdr(cce_pkg::OFS_POLY_LO, d);
    `CHK(d, 8'h04)
    wrr(cce_pkg::OFS_IRQ_EN, 8'h01);
    wrr(cce_pkg::OFS_CTRL_ONE, 8'hf7);
    for (int s = 0; s < 2; s++) begin
      wrr(cce_pkg::OFS_ACC_LO, 8'h00);
      wrr(cce_pkg::OFS_ACC_HI, 8'h00);
      wrr(cce_pkg::OFS_CTRL_ZERO, 8'h12 | 8'(s));
      for (int i = 0; i < 4; i++) begin
        word(16'ha555 + 16'h0011 * 16'(i));
      end
      wait_bit(cce_pkg::BIT_BUSY, 1'b0);
      acc(v);
      `CHK(v, s ? 16'h6ba2 : 16'h32d6)
      `CHK(irq, 1'b1)
    end
    wrr(cce_pkg::OFS_ACC_LO, 8'h00);
    wrr(cce_pkg::OFS_ACC_HI, 8'h00);
    wrr(cce_pkg::OFS_POLY_LO, 8'h00);
    wrr(cce_pkg::OFS_POLY_HI, 8'h00);
    wrr(cce_pkg::OFS_CTRL_ONE, 8'hff);
    word(v);
    wait_bit(cce_pkg::BIT_BUSY, 1'b0);
    acc(v);
    `CHK(v, 16'h45d6)
    wrr(cce_pkg::OFS_IRQ_EN, 8'h00);
    repeat (3) @(negedge clk_i);
    `CHK(irq, 1'b0)
    rdr(cce_pkg::OFS_FLAG, d);
    `CHK(d, 8'h01)
    wrr(cce_pkg::OFS_FLAG, 8'h00);
    rdr(cce_pkg::OFS_FLAG, d);
    `CHK(d, 8'h00)
    poly_v = 16'h0007;
    {poly_length_field_v, data_length_field_v, sm_v, am_v} = {32'd7, 32'd15, 32'd1, 32'd0};
    wrr(cce_pkg::OFS_POLY_LO, 8'h07);
    wrr(cce_pkg::OFS_POLY_HI, 8'h00);
    wrr(cce_pkg::OFS_CTRL_ONE, 8'h7f);
    wrr(cce_pkg::OFS_ACC_LO, 8'hff);
    wrr(cce_pkg::OFS_CTRL_ZERO, 8'h01);
    wrr(cce_pkg::OFS_DATA_HI, 8'h12);
    wrr(cce_pkg::OFS_DATA_LO, 8'h34);
    rdr(cce_pkg::OFS_CTRL_ZERO, d);
    `CHK(d[6:5], 2'b10)
    wrr(cce_pkg::OFS_CTRL_ZERO, 8'h11);
    wait_bit(cce_pkg::BIT_FULL, 1'b0);
    word(16'hbeef);
    wait_bit(cce_pkg::BIT_BUSY, 1'b0);
    acc(v);
    `CHK(v, crc_f(crc_f(16'h00ff, 16'h1234), 16'hbeef))
    rdr(cce_pkg::OFS_FLAG, d);
    `CHK(d, 8'h01)
    poly_v = 16'h1021;
    {poly_length_field_v, sm_v, am_v} = {32'd15, 32'd0, 32'd1};
    wrr(cce_pkg::OFS_POLY_LO, 8'h21);
    wrr(cce_pkg::OFS_POLY_HI, 8'h10);
    wrr(cce_pkg::OFS_CTRL_ONE, 8'hff);
    for (int s = 0; s < 2; s++) begin
      wrr(cce_pkg::OFS_ACC_LO, 8'hff);
      wrr(cce_pkg::OFS_ACC_HI, 8'hff);
      wrr(cce_pkg::OFS_CTRL_ZERO, 8'h12);
      base <= 16'h0100;
      cnt <= 4'h5;
      slow <= 1'(s);
      go <= 1'b1;
      for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk_i);
      `CHK(done, 1'b1)
      wait_bit(cce_pkg::BIT_BUSY, 1'b0);
      go <= 1'b0;
      e = 16'hffff;
      for (int i = 0; i < 5; i++) e = crc_f(e, 16'h0100 + 16'(i));
      acc(v);
      `CHK(v, e)
    end
    end_sim;
  end
endmodule
